//--- logic/abu_break_unit.v
// Function
// - enabled break plus full 16-bit program address match raises breakpoint request
// - break loads software interrupt opcode; vector FFFC, or FEFC in monitor mode
// - software writing 1 to active flag breaks before next instruction
// - match on opcode address: instruction waits until handler completes
// - match on operand address: instruction completes before break taken
// - return-from-interrupt inside handler ends break state
// - enable bit at bit 7, read/write, reset clears, 0 disables matches
// - active flag set on match, reset clears, handler clears by writing 0
// - cleared flag with unchanged address gives no further break after exit
// - address high and low byte registers read/write, reset to zero
// - timer counter stops while break state active
// - watchdog disable bit holds watchdog off during monitor-mode break
// - wait-exit indicator reads 1 when break ended wait mode, else 0
// - wait status register works only in emulation mode
// - in break, status flags clear only when clear-enable bit is 1
// - no address-match break while in wait or stop mode
// - timer low byte latched by high read in break persists until read
`timescale 1ns/1ps
`include "abu_defines.vh"
module abu_break_unit (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire [`ABU_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [15:0] cpu_addr,
   input wire cpu_opcode_fetch,
   input wire cpu_instr_start,
   input wire cpu_rti_done,
   input wire cpu_low_power,
   input wire wait_exit_event,
   input wire monitor_mode,
   input wire emulation_mode,
   input wire [15:0] timer_count,
   input wire timer_high_rd,
   input wire timer_low_rd,
   output wire breakpoint_request,
   output wire break_state,
   output wire [7:0] forced_opcode,
   output wire [15:0] break_vector,
   output wire timer_freeze,
   output wire watchdog_hold,
   output wire status_clear_allow,
   output reg [7:0] timer_low_latched
);
   localparam [7:0] SWI_OPCODE = 8'h83;
   localparam ST_IDLE = 2'b00;
   localparam ST_PEND = 2'b01;
   localparam ST_BRK = 2'b10;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg break_enable_bit_r;
   reg break_active_flag_r;
   reg [7:0] addr_high_r;
   reg [7:0] addr_low_r;
   reg watchdog_disable_in_break_r;
   reg wait_exit_by_break_flag_r;
   reg break_clear_enable_r;
   reg match_armed_r;
   reg low_latched_valid_r;
   reg [7:0] rdata_nxt;
   reg active_nxt;
   reg armed_nxt;
   reg wait_flag_nxt;
   reg break_enable_nxt;
   reg [7:0] addr_high_nxt;
   reg [7:0] addr_low_nxt;
   reg wddis_nxt;
   reg clren_nxt;

   wire wr_ctrl;
   wire wr_addrh;
   wire wr_addrl;
   wire wr_aux;
   wire wr_flagctl;
   wire addr_wr;
   wire sw_set;
   wire sw_clear;
   wire [15:0] addr_word;
   wire [15:0] bit_eq;
   wire addr_hit;
   wire match;
   wire fire_now;
   wire fire_later;
   wire in_idle;
   wire in_pend;
   wire in_brk;
   wire [7:0] ctrl_byte;
   wire [7:0] aux_byte;
   wire [7:0] waitst_byte;
   wire [7:0] flagctl_byte;

   // one decode per writable register keeps each write strobe easy to follow
   assign wr_ctrl = reg_wr && (reg_addr == `ABU_OFS_CTRL);
   assign wr_addrh = reg_wr && (reg_addr == `ABU_OFS_ADDRH);
   assign wr_addrl = reg_wr && (reg_addr == `ABU_OFS_ADDRL);
   assign wr_aux = reg_wr && (reg_addr == `ABU_OFS_AUX);
   assign wr_flagctl = reg_wr && (reg_addr == `ABU_OFS_FLAGCTL);
   assign addr_wr = wr_addrh || wr_addrl;
   assign sw_set = wr_ctrl && reg_wdata[`ABU_BIT_ACTIVE];
   assign sw_clear = wr_ctrl && !reg_wdata[`ABU_BIT_ACTIVE];

   // both bytes form one compare word so a match needs all 16 address bits equal
   assign addr_word = {addr_high_r, addr_low_r};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_cmp
         assign bit_eq[gi] = (cpu_addr[gi] == addr_word[gi]);
      end
   endgenerate

   assign addr_hit = &bit_eq;
   // no match while bus is frozen in low-power modes
   assign match = break_enable_bit_r && addr_hit && !cpu_low_power && match_armed_r;

   // opcode match cancels that instruction, operand match lets it finish first
   assign fire_now = match && cpu_opcode_fetch;
   assign fire_later = match && !cpu_opcode_fetch;

   assign in_idle = (state_r == ST_IDLE);
   assign in_pend = (state_r == ST_PEND);
   assign in_brk = (state_r == ST_BRK);

   // readable bytes built bit by bit from the field positions; unused bits read zero
   genvar bi;
   generate
      for (bi = 0; bi < 8; bi = bi + 1) begin : g_fields
         assign ctrl_byte[bi] = (bi == `ABU_BIT_ENABLE) ? break_enable_bit_r :
            (bi == `ABU_BIT_ACTIVE) ? break_active_flag_r : 1'b0;
         assign aux_byte[bi] = (bi == `ABU_BIT_WDDIS) ? watchdog_disable_in_break_r : 1'b0;
         assign waitst_byte[bi] = (bi == `ABU_BIT_WAITEXIT) ? wait_exit_by_break_flag_r : 1'b0;
         assign flagctl_byte[bi] = (bi == `ABU_BIT_CLREN) ? break_clear_enable_r : 1'b0;
      end
   endgenerate

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (fire_now) begin
               state_nxt = ST_BRK;
            end else if (fire_later || sw_set) begin
               state_nxt = ST_PEND;
            end
         end
         ST_PEND: begin
            if (cpu_instr_start) begin
               state_nxt = ST_BRK;
            end
         end
         ST_BRK: begin
            if (cpu_rti_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // set wins over a same-cycle software clear so a match is never lost
   always @* begin
      active_nxt = break_active_flag_r;
      if (match || sw_set) begin
         active_nxt = 1'b1;
      end else if (sw_clear) begin
         active_nxt = 1'b0;
      end
   end

   // after a break on an address, re-arm only once that address is rewritten
   always @* begin
      armed_nxt = match_armed_r;
      if (match) begin
         armed_nxt = 1'b0;
      end else if (addr_wr) begin
         armed_nxt = 1'b1;
      end
   end

   // only emulation mode keeps this flag; outside it the flag reads as zero
   always @* begin
      wait_flag_nxt = wait_exit_by_break_flag_r;
      if (!emulation_mode) begin
         wait_flag_nxt = 1'b0;
      end else if (wait_exit_event && (state_nxt != ST_IDLE)) begin
         wait_flag_nxt = 1'b1;
      end else if (cpu_rti_done) begin
         wait_flag_nxt = 1'b0;
      end
   end

   // read data is zero outside the cycle after a read strobe
   always @* begin
      rdata_nxt = `ABU_RST_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            `ABU_OFS_CTRL: begin
               rdata_nxt = ctrl_byte;
            end
            `ABU_OFS_ADDRH: begin
               rdata_nxt = addr_high_r;
            end
            `ABU_OFS_ADDRL: begin
               rdata_nxt = addr_low_r;
            end
            `ABU_OFS_AUX: begin
               rdata_nxt = aux_byte;
            end
            `ABU_OFS_WAITST: begin
               rdata_nxt = waitst_byte;
            end
            `ABU_OFS_FLAGCTL: begin
               rdata_nxt = flagctl_byte;
            end
            default: begin
               rdata_nxt = `ABU_RST_BYTE;
            end
         endcase
      end
   end

   always @* begin
      break_enable_nxt = break_enable_bit_r;
      if (wr_ctrl) begin
         break_enable_nxt = reg_wdata[`ABU_BIT_ENABLE];
      end
   end

   always @* begin
      addr_high_nxt = addr_high_r;
      if (wr_addrh) begin
         addr_high_nxt = reg_wdata;
      end
   end

   always @* begin
      addr_low_nxt = addr_low_r;
      if (wr_addrl) begin
         addr_low_nxt = reg_wdata;
      end
   end

   always @* begin
      wddis_nxt = watchdog_disable_in_break_r;
      if (wr_aux) begin
         wddis_nxt = reg_wdata[`ABU_BIT_WDDIS];
      end
   end

   always @* begin
      clren_nxt = break_clear_enable_r;
      if (wr_flagctl) begin
         clren_nxt = reg_wdata[`ABU_BIT_CLREN];
      end
   end

   // ce low freezes every register, read data included
   always @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         break_enable_bit_r <= 1'b0;
      end else if (ce) begin
         break_enable_bit_r <= break_enable_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         break_active_flag_r <= 1'b0;
      end else if (ce) begin
         break_active_flag_r <= active_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         match_armed_r <= 1'b1;
      end else if (ce) begin
         match_armed_r <= armed_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         addr_high_r <= `ABU_RST_BYTE;
      end else if (ce) begin
         addr_high_r <= addr_high_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         addr_low_r <= `ABU_RST_BYTE;
      end else if (ce) begin
         addr_low_r <= addr_low_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         watchdog_disable_in_break_r <= 1'b0;
      end else if (ce) begin
         watchdog_disable_in_break_r <= wddis_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         break_clear_enable_r <= 1'b0;
      end else if (ce) begin
         break_clear_enable_r <= clren_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         wait_exit_by_break_flag_r <= 1'b0;
      end else if (ce) begin
         wait_exit_by_break_flag_r <= wait_flag_nxt;
      end
   end

   // latch survives the end of break until software reads the low byte
   always @(posedge clk) begin
      if (!rst_n) begin
         timer_low_latched <= `ABU_RST_BYTE;
         low_latched_valid_r <= 1'b0;
      end else if (ce) begin
         if (timer_high_rd && !low_latched_valid_r) begin
            timer_low_latched <= timer_count[7:0];
            low_latched_valid_r <= 1'b1;
         end else if (timer_low_rd) begin
            low_latched_valid_r <= 1'b0;
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= `ABU_RST_BYTE;
      end else if (ce) begin
         reg_rdata <= rdata_nxt;
      end
   end

   assign breakpoint_request = (in_idle && fire_now) || (in_pend && cpu_instr_start);
   assign break_state = in_brk;
   assign forced_opcode = SWI_OPCODE;
   assign break_vector = monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
   assign timer_freeze = break_state;
   assign watchdog_hold = break_state && monitor_mode && watchdog_disable_in_break_r;
   assign status_clear_allow = !break_state || break_clear_enable_r;
endmodule

//--- logic/abu_defines.vh
`ifndef ABU_DEFINES_VH
`define ABU_DEFINES_VH
`define ABU_ADDR_W 3
`define ABU_OFS_CTRL 3'h0
`define ABU_OFS_ADDRH 3'h1
`define ABU_OFS_ADDRL 3'h2
`define ABU_OFS_AUX 3'h3
`define ABU_OFS_WAITST 3'h4
`define ABU_OFS_FLAGCTL 3'h5
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WDDIS 0
`define ABU_BIT_WAITEXIT 1
`define ABU_BIT_CLREN 7
`define ABU_RST_BYTE 8'h00
`define ABU_VEC_NORMAL 16'hFFFC
`define ABU_VEC_MONITOR 16'hFEFC
`endif

//--- testbench/abu_break_unit_bench.sv
`timescale 1ns/1ps
`define CHK(a,b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("Error %0t mismatch", $time); end end
module abu_break_unit_bench;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, lp = 0, wx = 0, mon = 0, hr = 0, run = 0, return_from_interrupt_instruction = 0;
   logic [2:0] ad = 0;
   logic [7:0] wd = 0, rdata, tl;
   logic [15:0] ca, vec, tc = 16'hABCD;
   logic bp, bs, of, is, rdn, tf, sca, wh;
   int errors = 0, comparisons = 0;
   always #50 clk = ~clk;
   abu_cpu_model cpu (.clk(clk), .run(run), .pc0(16'h1230), .rti_req(return_from_interrupt_instruction), .break_state(bs), .cpu_addr(ca),
      .cpu_opcode_fetch(of), .cpu_instr_start(is), .cpu_rti_done(rdn));
   abu_break_unit DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .cpu_addr(ca), .cpu_opcode_fetch(of), .cpu_instr_start(is), .cpu_rti_done(rdn),
      .cpu_low_power(lp), .wait_exit_event(wx), .monitor_mode(mon), .emulation_mode(1'b1), .timer_count(tc),
      .timer_high_rd(hr), .timer_low_rd(1'b0), .breakpoint_request(bp), .break_state(bs), .forced_opcode(),
      .break_vector(vec), .timer_freeze(tf), .watchdog_hold(wh), .status_clear_allow(sca), .timer_low_latched(tl));
   task tally_and_finish;
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task w(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk); ad <= a; wd <= d; wr <= 1;
      @(posedge clk); wr <= 0;
   endtask
   task r(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk); ad <= a; rd <= 1;
      @(posedge clk); rd <= 0;
      @(negedge clk); `CHK(rdata, e)
   endtask
   // bounded wait on the break level; running out ends the run
   task wt(input logic v);
      for (int i = 0; i < 40 && bs !== v; i++) @(negedge clk);
      `CHK(bs, v)
      if (bs !== v) tally_and_finish();
   endtask
   task ret;
      @(posedge clk); return_from_interrupt_instruction <= 1;
      @(posedge clk); return_from_interrupt_instruction <= 0;
      wt(0);
   endtask
   task go;
      @(posedge clk); run <= 0;
      @(posedge clk); run <= 1;
   endtask
   task t_regs;
      for (int a = 0; a < 7; a++) r(a[2:0], 8'h00);
      w(1, 8'h12);
      w(2, 8'h34);
      r(1, 8'h12);
      r(2, 8'h34);
   endtask
   task t_match;
      w(0, 8'h80);
      go;
      wt(1);
      `CHK(vec, 16'hFFFC)
      r(0, 8'hC0);
      w(0, 8'h80);
      ret;
      go;
      repeat (20) @(negedge clk);
      `CHK(bs, 1'b0)
      w(2, 8'h34);
      go;
      wt(1);
      w(0, 8'h80);
      ret;
   endtask
   task t_off;
      w(2, 8'h34);
      w(0, 8'h00);
      go;
      repeat (20) @(negedge clk);
      `CHK(bs, 1'b0)
      w(2, 8'h34);
      w(0, 8'h80);
      lp <= 1;
      go;
      repeat (20) @(negedge clk);
      `CHK(bs, 1'b0)
      @(posedge clk);
      lp <= 0;
      run <= 0;
   endtask
   task t_soft;
      mon <= 1;
      w(0, 8'h40);
      go;
      wt(1);
      `CHK(vec, 16'hFEFC)
      w(3, 8'h01);
      @(negedge clk);
      `CHK(wh, 1'b1)
      @(posedge clk);
      wx <= 1;
      hr <= 1;
      @(posedge clk);
      wx <= 0;
      hr <= 0;
      tc <= 16'h0000;
      @(negedge clk);
      `CHK(tf, 1'b1)
      `CHK(sca, 1'b0)
      r(4, 8'h02);
      w(5, 8'h80);
      @(negedge clk);
      `CHK(sca, 1'b1)
      w(0, 8'h00);
      ret;
      `CHK(wh, 1'b0)
      `CHK(tf, 1'b0)
      r(4, 8'h00);
      @(posedge clk);
      mon <= 0;
      @(negedge clk);
      `CHK(tl, 8'hCD)
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      t_regs; t_match; t_off; t_soft;
      tally_and_finish;
   end
endmodule
bind abu_break_unit abu_break_unit_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .cpu_low_power(cpu_low_power),
   .cpu_rti_done(cpu_rti_done), .monitor_mode(monitor_mode), .breakpoint_request(breakpoint_request),
   .break_state(break_state), .break_vector(break_vector), .timer_freeze(timer_freeze),
   .status_clear_allow(status_clear_allow));

//--- testbench/abu_break_unit_chk.sv
`timescale 1ns/1ps
module abu_break_unit_chk (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire cpu_low_power,
   input wire cpu_rti_done,
   input wire monitor_mode,
   input wire breakpoint_request,
   input wire break_state,
   input wire [15:0] break_vector,
   input wire timer_freeze,
   input wire status_clear_allow
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_vector_select: assert property (break_vector == (monitor_mode ? 16'hFEFC : 16'hFFFC))
      else $error("vector wrong");
   a_freeze_tracks: assert property (timer_freeze == break_state) else $error("freeze wrong");
   a_no_lowpwr_req: assert property (cpu_low_power |-> !breakpoint_request) else $error("req in wait");
   a_req_to_state: assert property (breakpoint_request && ce && !cpu_rti_done |=> break_state)
      else $error("no break");
   a_rti_ends: assert property (break_state && cpu_rti_done && ce |=> !break_state) else $error("rti ignored");
   a_state_holds: assert property (break_state && !cpu_rti_done |=> break_state) else $error("break lost");
   a_rise_cause: assert property ($rose(break_state) |-> $past(breakpoint_request)) else $error("stray break");
   a_clear_outside: assert property (!break_state |-> status_clear_allow) else $error("clear blocked");
   cover property (breakpoint_request && !break_state);
   cover property (break_state && cpu_rti_done);
   cover property (break_state && monitor_mode);
endmodule

//--- testbench/abu_cpu_model.sv
`timescale 1ns/1ps
module abu_cpu_model (
   input wire clk,
   input wire run,
   input wire [15:0] pc0,
   input wire rti_req,
   input wire break_state,
   output logic [15:0] cpu_addr,
   output wire cpu_opcode_fetch,
   output wire cpu_instr_start,
   output logic cpu_rti_done
);
   // even addresses carry opcodes, odd ones operands: keeps both match kinds reachable
   assign cpu_opcode_fetch = run && !cpu_addr[0];
   assign cpu_instr_start = cpu_opcode_fetch && !break_state;
   always @(posedge clk) begin
      cpu_rti_done <= rti_req;
      if (!run)
         cpu_addr <= pc0;
      else if (!break_state)
         cpu_addr <= cpu_addr + 16'h0001;
   end
endmodule
